// ---- design/cprm_mux.sv ----
// Configuration pin reuse mux: per-group choice of configuration role
// or general-purpose I/O, plus the pin-level steering of the reload, slave and master serial groups.
// Assumes the configuration engine reports completion with a level and
// loads the static reuse options before it does.
`timescale 1ns/1ps
`default_nettype none

`include "cprm_defs.svh"

module cprm_mux
  import cprm_pkg::*;
(
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_cfg_done,
  input  wire logic                       i_opt_load,
  input  wire logic [`CPRM_OPT_W-1:0]     i_opt,
  input  wire logic [`CPRM_MODE_W-1:0]    i_mode_pin,
  input  wire logic                       i_test_port_reclaim_n,
  input  wire logic                       i_reload_trigger_n,
  input  wire logic                       i_user_reload_out,
  input  wire logic                       i_user_reload_oe,
  input  wire logic [`CPRM_SER_PINS-1:0]  i_ssp_pin,
  input  wire logic [`CPRM_SER_PINS-1:0]  i_msp_pin,
  output logic                            o_user_mode,
  output logic                            o_test_gpio,
  output logic                            o_twi_gpio,
  output logic                            o_ssp_gpio,
  output logic                            o_msp_gpio,
  output logic                            o_reload_gpio,
  output logic                            o_ready_gpio,
  output logic                            o_done_gpio,
  output logic                            o_reclaim_gpio,
  output logic                            o_cfg_reload_n,
  output logic                            o_reload_trigger_n_o,
  output logic                            o_reload_trigger_n_oe,
  output logic [`CPRM_SER_PINS-1:0]       o_ssp_cfg,
  output logic [`CPRM_SER_PINS-1:0]       o_ssp_user,
  output logic [`CPRM_SER_PINS-1:0]       o_msp_cfg,
  output logic [`CPRM_SER_PINS-1:0]       o_msp_user
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int SYNC_W = 3 + `CPRM_MODE_W + 2 * `CPRM_SER_PINS;

  logic [SYNC_W-1:0]              sync_q;
  logic                           done_s;
  logic                           reclaim_n_s;
  logic                           rld_act_s;
  logic [`CPRM_MODE_W-1:0]        mode_s;
  logic [`CPRM_SER_PINS-1:0]      ssp_s;
  logic [`CPRM_SER_PINS-1:0]      msp_s;

  cprm_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_cfg_done, i_test_port_reclaim_n, ~i_reload_trigger_n, i_mode_pin,
             i_ssp_pin, i_msp_pin}),
    .o_q   (sync_q)
  );

  assign {done_s, reclaim_n_s, rld_act_s, mode_s, ssp_s, msp_s} = sync_q;

  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  cprm_ctl_s ctl_r;
  cprm_ctl_s ctl_nxt;
  logic      test_free;
  logic      rld_in_s;

  // Reload level synced inverted so the flops reset to the idle high
  // level; no false reload reaches the engine after reset.
  assign rld_in_s = ~rld_act_s;

  always_comb
  begin
    ctl_nxt = ctl_r;
    case (ctl_r.state)
      CPRM_CONFIG:
      begin
        if (i_opt_load)
        begin
          ctl_nxt.opt = i_opt;
        end
        if (done_s)
        begin
          ctl_nxt.state = CPRM_USER;
        end
      end
      CPRM_USER:
      begin
        // Options latched once at the user-mode edge, then frozen
        ctl_nxt.perm          = (mode_s == `CPRM_MODE_PERM);
        ctl_nxt.role.twi      = ctl_r.opt[`CPRM_OPT_TWI];
        ctl_nxt.role.ssp      = ctl_r.opt[`CPRM_OPT_SSP];
        ctl_nxt.role.msp      = ctl_r.opt[`CPRM_OPT_MSP];
        ctl_nxt.role.reload   = ctl_r.opt[`CPRM_OPT_RELOAD];
        ctl_nxt.role.ready    = ctl_r.opt[`CPRM_OPT_READY];
        ctl_nxt.role.done     = ctl_r.opt[`CPRM_OPT_DONE];
        ctl_nxt.state         = CPRM_HOLD;
      end
      CPRM_HOLD:
      begin
        ctl_nxt.state = CPRM_HOLD;
      end
      default:
      begin
        ctl_nxt.state = CPRM_CONFIG;
      end
    endcase
    // Test port: live reclaim unless the strap pins it
    test_free = ctl_r.opt[`CPRM_OPT_TEST] && (ctl_r.perm || reclaim_n_s);
    if (ctl_nxt.state == CPRM_HOLD)
    begin
      ctl_nxt.role.test = (ctl_r.state == CPRM_HOLD) ? test_free : 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // Device reset restores every configuration role
      ctl_r <= '{state: CPRM_CONFIG, opt: '0, perm: 1'b0, role: '0};
    end
    else
    begin
      ctl_r <= ctl_nxt;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_user_mode           <= 1'b0;
      o_test_gpio           <= 1'b0;
      o_twi_gpio            <= 1'b0;
      o_ssp_gpio            <= 1'b0;
      o_msp_gpio            <= 1'b0;
      o_reload_gpio         <= 1'b0;
      o_ready_gpio          <= 1'b0;
      o_done_gpio           <= 1'b0;
      o_reclaim_gpio        <= 1'b1;
      o_cfg_reload_n        <= 1'b1;
      o_reload_trigger_n_o  <= 1'b1;
      o_reload_trigger_n_oe <= 1'b0;
      o_ssp_cfg             <= '0;
      o_ssp_user            <= '0;
      o_msp_cfg             <= '0;
      o_msp_user            <= '0;
    end
    else
    begin
      o_user_mode    <= (ctl_r.state == CPRM_HOLD);
      o_test_gpio    <= ctl_r.role.test;
      o_twi_gpio     <= ctl_r.role.twi;
      o_ssp_gpio     <= ctl_r.role.ssp;
      o_msp_gpio     <= ctl_r.role.msp;
      o_reload_gpio  <= ctl_r.role.reload;
      o_ready_gpio   <= ctl_r.role.ready;
      o_done_gpio    <= ctl_r.role.done;
      // Reclaim pin keeps its default user role until the options apply
      o_reclaim_gpio <= (ctl_r.state != CPRM_HOLD) || ctl_r.perm
                        || !ctl_r.opt[`CPRM_OPT_TEST];
      // Reused reload pin never feeds the engine; output only
      o_cfg_reload_n        <= ctl_r.role.reload ? 1'b1 : rld_in_s;
      o_reload_trigger_n_o  <= ctl_r.role.reload ? i_user_reload_out : 1'b1;
      o_reload_trigger_n_oe <= ctl_r.role.reload && i_user_reload_oe;
      o_ssp_cfg             <= ctl_r.role.ssp ? '0 : ssp_s;
      o_ssp_user            <= ctl_r.role.ssp ? ssp_s : '0;
      o_msp_cfg             <= ctl_r.role.msp ? '0 : msp_s;
      o_msp_user            <= ctl_r.role.msp ? msp_s : '0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  no_early_free_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_user_mode |-> !(o_twi_gpio || o_ssp_gpio || o_msp_gpio || o_test_gpio))
    else $error("pin freed before user mode");

  user_entry_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctl_r.state == CPRM_CONFIG && done_s) |-> ##3 o_user_mode)
    else $error("user mode not entered three cycles after done");

  reclaim_back_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctl_r.state == CPRM_HOLD && !ctl_r.perm && !reclaim_n_s) |-> ##2 !o_test_gpio)
    else $error("reclaim did not restore test pins");

  test_free_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctl_r.state == CPRM_HOLD && ctl_r.opt[`CPRM_OPT_TEST] && reclaim_n_s)
      |-> ##2 o_test_gpio)
    else $error("test pins not freed with reclaim high");

  perm_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctl_r.state == CPRM_HOLD && ctl_r.perm && ctl_r.opt[`CPRM_OPT_TEST])
      |-> ##2 o_test_gpio)
    else $error("strap 001 let reclaim restore test pins");

  twi_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_user_mode) |-> o_twi_gpio == ctl_r.opt[`CPRM_OPT_TWI])
    else $error("two-wire role differs from option");

  opt_frozen_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctl_r.state == CPRM_HOLD) |=> $stable(ctl_r.opt))
    else $error("reuse option changed in user mode");

  reload_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_reload_gpio |-> o_cfg_reload_n)
    else $error("reused reload pin reached the engine");

  ssp_split_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_ssp_gpio |-> (o_ssp_user == '0))
    else $error("slave port leaked to user while dedicated");

  reclaim_dflt_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_user_mode |-> o_reclaim_gpio)
    else $error("reclaim pin left its default role before user mode");

endmodule

`default_nettype wire

// ---- design/cprm_defs.svh ----
// Constants for the configuration pin reuse mux.
// Assumes inclusion by the package and design files by bare name.
`ifndef CPRM_DEFS_SVH
`define CPRM_DEFS_SVH

// ------------------------------------------------------------
// Reuse option bit positions
// ------------------------------------------------------------
`define CPRM_OPT_TEST    0
`define CPRM_OPT_TWI     1
`define CPRM_OPT_SSP     2
`define CPRM_OPT_MSP     3
`define CPRM_OPT_RELOAD  4
`define CPRM_OPT_READY   5
`define CPRM_OPT_DONE    6
`define CPRM_OPT_W       7

// ------------------------------------------------------------
// Mode strap
// ------------------------------------------------------------
`define CPRM_MODE_W      3
`define CPRM_MODE_PERM   3'h1

// Pins per serial group
`define CPRM_SER_PINS    5

`endif

// ---- design/cprm_pkg.sv ----
// Types for the configuration pin reuse mux.
// Assumes cprm_defs.svh is on the include path.
`include "cprm_defs.svh"

package cprm_pkg;

  typedef logic [`CPRM_OPT_W-1:0] cprm_opt_t;

  // Pin role per group: 1 = general-purpose I/O, 0 = configuration role
  typedef struct packed {
    logic test;
    logic twi;
    logic ssp;
    logic msp;
    logic reload;
    logic ready;
    logic done;
  } cprm_role_s;

  typedef enum logic [2:0] {
    CPRM_CONFIG = 3'h1,
    CPRM_USER   = 3'h2,
    CPRM_HOLD   = 3'h4
  } cprm_state_e;

  typedef struct packed {
    cprm_state_e state;
    cprm_opt_t   opt;
    logic        perm;
    cprm_role_s  role;
  } cprm_ctl_s;

endpackage

// ---- design/cprm_sync.sv ----
// Two-flop synchroniser for a bus of pin levels.
// Assumes a single clock; inputs may be asynchronous.
`timescale 1ns/1ps
`default_nettype none

module cprm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // Refused at elaboration: an empty bus has nothing to carry
  if (W < 1)
  begin : g_bad_width
    $error("cprm_sync: W must be at least 1");
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= '0;
      o_q    <= '0;
    end
    else
    begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

`default_nettype wire

// ---- verification/cprm_board.sv ----
// Board model: mode strap, reclaim pin, reload pin and serial pin levels.
// Assumes the bench sets the wanted levels; pins follow one clock later.
`timescale 1ns/1ps
`default_nettype none

module cprm_board (
  input  wire logic       i_clk,
  input  wire logic [2:0] i_mode,
  input  wire logic       i_reclaim_n,
  input  wire logic       i_reload_n,
  input  wire logic [4:0] i_ssp,
  input  wire logic [4:0] i_msp,
  input  wire logic       i_dev_o,
  input  wire logic       i_dev_oe,
  output logic      [2:0] o_mode_pin,
  output logic            o_reclaim_n,
  output logic            o_reload_pin,
  output logic      [4:0] o_ssp,
  output logic      [4:0] o_msp
);
  logic board_reload_n;

  always_ff @(posedge i_clk)
  begin
    o_mode_pin     <= i_mode;
    o_reclaim_n    <= i_reclaim_n;
    board_reload_n <= i_reload_n;
    o_ssp          <= i_ssp;
    o_msp          <= i_msp;
  end

  // Board lets go of the pin whenever the device drives it
  assign o_reload_pin = i_dev_oe ? i_dev_o : board_reload_n;
endmodule

`default_nettype wire

// ---- verification/config_pin_reuse_mux_tb.sv ----
// Self-checking bench for the configuration pin reuse mux.
// Assumes cprm_pkg and cprm_defs.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cprm_defs.svh"

module config_pin_reuse_mux_tb
  import cprm_pkg::*;
;
  typedef struct {int k; logic [19:0] v;} cprm_note_s;
  logic       i_clk    = 1'b0;
  logic       i_rst    = 1'b1;
  logic       cfg_done = 1'b0;
  logic       opt_load = 1'b0;
  logic       uout     = 1'b0;
  logic       uoe      = 1'b0;
  logic       rcl_n    = 1'b1;
  logic       rld_n    = 1'b1;
  logic [6:0] opt      = 7'h0;
  logic [2:0] mode     = 3'h0;
  logic [4:0] ssp      = 5'h0;
  logic [4:0] msp      = 5'h0;
  logic [4:0] ssp_p, msp_p, ssp_c, ssp_u, msp_c, msp_u;
  logic [2:0] mode_p;
  logic       rcl_p, rld_p, um, tg, wg, sg, mg, lg, yg, dg, cg, crn, ro, roe;
  cprm_note_s q[$];
  cprm_note_s cur;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         seed       = 32'h89e5;

  always #2.5 i_clk = ~i_clk;

  cprm_board board_u (.i_clk(i_clk), .i_mode(mode), .i_reclaim_n(rcl_n), .i_reload_n(rld_n),
    .i_ssp(ssp), .i_msp(msp), .i_dev_o(ro), .i_dev_oe(roe), .o_mode_pin(mode_p),
    .o_reclaim_n(rcl_p), .o_reload_pin(rld_p), .o_ssp(ssp_p), .o_msp(msp_p));

  cprm_mux dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cfg_done(cfg_done), .i_opt_load(opt_load),
    .i_opt(opt), .i_mode_pin(mode_p), .i_test_port_reclaim_n(rcl_p),
    .i_reload_trigger_n(rld_p), .i_user_reload_out(uout), .i_user_reload_oe(uoe),
    .i_ssp_pin(ssp_p), .i_msp_pin(msp_p), .o_user_mode(um), .o_test_gpio(tg),
    .o_twi_gpio(wg), .o_ssp_gpio(sg), .o_msp_gpio(mg), .o_reload_gpio(lg), .o_ready_gpio(yg),
    .o_done_gpio(dg), .o_reclaim_gpio(cg), .o_cfg_reload_n(crn), .o_reload_trigger_n_o(ro),
    .o_reload_trigger_n_oe(roe), .o_ssp_cfg(ssp_c), .o_ssp_user(ssp_u), .o_msp_cfg(msp_c),
    .o_msp_user(msp_u));

  // ------------------------------------------------------------
  // Comparison side
  // ------------------------------------------------------------
  task automatic report(input logic [19:0] a, input logic [19:0] e);
    tests_run++;
    if (a !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, a, e);
    end
  endtask

  task automatic cmp_roles(input logic [19:0] e);
    report({12'h0, um, tg, wg, sg, mg, lg, yg, dg}, e);
  endtask

  task automatic cmp_reload(input logic [19:0] e);
    report({16'h0, crn, roe, roe & ro, cg}, e);
  endtask

  task automatic cmp_serial(input logic [19:0] e);
    report({ssp_c, ssp_u, msp_c, msp_u}, e);
  endtask

  // Outputs are settled half a cycle after the launching edge
  always @(negedge i_clk)
    while (q.size() > 0)
    begin
      cur = q.pop_front();
      case (cur.k)
        0:       cmp_roles(cur.v);
        1:       cmp_reload(cur.v);
        default: cmp_serial(cur.v);
      endcase
    end

  // ------------------------------------------------------------
  // Stimulus side
  // ------------------------------------------------------------
  task automatic note(input int k, input logic [19:0] v);
    q.push_back('{k, v});
  endtask

  task automatic run_case(input int i);
    logic [6:0] o2;
    logic       perm;
    i_rst    <= 1'b1;
    cfg_done <= 1'b0;
    repeat (8) @(posedge i_clk);
    note(0, 20'h0);
    note(1, 20'h9);
    opt   <= (i < 7) ? 7'h1 << i : 7'($random(seed));
    mode  <= (i % 3 == 0) ? `CPRM_MODE_PERM : 3'($random(seed));
    {ssp, msp, rcl_n, rld_n, uout, uoe} <= 14'($random(seed));
    i_rst <= 1'b0;
    @(posedge i_clk);
    opt_load <= 1'b1;
    @(posedge i_clk);
    opt_load <= 1'b0;
    repeat (6) @(posedge i_clk);
    o2   = opt;
    perm = (mode == `CPRM_MODE_PERM);
    note(0, 20'h0);
    note(1, {16'h0, rld_n, 3'h1});
    note(2, {ssp, 5'h0, msp, 5'h0});
    cfg_done <= 1'b1;
    repeat (8) @(posedge i_clk);
    note(0, {12'h0, 1'b1, o2[0] & (perm | rcl_n), o2[1], o2[2], o2[3], o2[4], o2[5], o2[6]});
    note(1, {16'h0, o2[4] | rld_n, o2[4] & uoe, o2[4] & uoe & uout, ~o2[0] | perm});
    note(2, {o2[2] ? 5'h0 : ssp, o2[2] ? ssp : 5'h0,
             o2[3] ? 5'h0 : msp, o2[3] ? msp : 5'h0});
    // Late load must not disturb the roles already in force
    opt      <= ~o2;
    opt_load <= 1'b1;
    rcl_n    <= ~rcl_n;
    @(posedge i_clk);
    opt_load <= 1'b0;
    repeat (8) @(posedge i_clk);
    note(0, {12'h0, 1'b1, o2[0] & (perm | rcl_n), o2[1], o2[2], o2[3], o2[4], o2[5], o2[6]});
    @(posedge i_clk);
    $display("case %0d done, opt %h mode %h", i, o2, mode);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 12; i++)
      run_case(i);
    repeat (2) @(posedge i_clk);
    wrap_up();
  end

  // About 34 cycles a case; a hang is cut well beyond that
  initial
  begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule

`default_nettype wire
